/* include/slp_pkg.sv */
/*
  Package for the synthesizer latch and power-down block: field positions,
  latch select codes and widths.
  Assumes a 24-bit serial word with two select bits in the low positions.
*/
package slp_pkg;
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_FUNCTION = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_DIVIDER = 2'h2;
  // Function control latch fields
  localparam int FN_PRESCALER_HI = 23;
  localparam int FN_PRESCALER_LO = 22;
  localparam int FN_PD_SYNC = 21;
  localparam int FN_PD_ARM = 20;
  localparam int FN_CUR2_HI = 19;
  localparam int FN_CUR2_LO = 17;
  localparam int FN_CUR1_HI = 16;
  localparam int FN_CUR1_LO = 14;
  localparam int FN_MUTE = 11;
  localparam int FN_GAIN = 10;
  localparam int FN_TRISTATE = 9;
  // Divider latch fields
  localparam int DV_HALF_FB = 23;
  localparam int DV_HALVER = 22;
  localparam int DV_GAIN = 21;
  localparam int DV_MAIN_HI = 20;
  localparam int DV_MAIN_LO = 8;
  localparam int DV_SPARE = 7;
  localparam int DV_SWAL_HI = 6;
  localparam int DV_SWAL_LO = 2;
  // Reference latch fields
  localparam int RF_BAND_HI = 21;
  localparam int RF_BAND_LO = 20;
  localparam int RF_TEST = 19;
  localparam int RF_LDP = 18;
  localparam int RF_ABP_HI = 17;
  localparam int RF_ABP_LO = 16;
  localparam int RF_RDIV_HI = 15;
  localparam int RF_RDIV_LO = 2;
  // Reset values (none documented: all zero) and reference edges for synchronous power-down
  localparam logic [23:0] LATCH_RST = 24'h000000;
  localparam logic [1:0] SYNC_EDGES = 2'h2;
endpackage : slp_pkg

/* src/slp_core.sv */
/*
  Serial latch bank with power-down control of a frequency synthesizer.
  Assumes the shift clock, data, load strobe, chip enable, reference divider
  output and lock flag are asynchronous pins, sampled on clk_in.
*/
module slp_core
  import slp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Serial link pins
  input wire logic shift_clk_in,
  input wire logic shift_data_in,
  input wire logic load_strobe_in,
  // Device pins and analog feedback
  input wire logic chip_enable_in,
  input wire logic ref_div_out_in,
  input wire logic loop_locked_in,
  // Latch contents
  output logic [WORD_W-1:0] function_control_latch_out,
  output logic [WORD_W-1:0] reference_divider_latch_out,
  output logic [WORD_W-1:0] divider_word_latch_out,
  // Decoded controls
  output logic [1:0] prescaler_select_out,
  output logic [2:0] pump_current_out,
  output logic pump_gain_select_out,
  output logic pump_tristate_out,
  output logic counters_hold_out,
  output logic lock_detect_clear_out,
  output logic rf_output_enable_out,
  output logic ref_buffer_enable_out,
  output logic powered_up_out,
  output logic band_search_out,
  output logic powered_down_out
);
  logic [2:0] sclk_s_r, le_s_r;
  logic [1:0] data_s_r, ce_s_r, lock_s_r;
  logic [2:0] ref_s_r;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] fn_r, rf_r, dv_r;
  logic gain_r, pd_r, sync_pend_r, powered_r, band_req_r;
  logic [1:0] edge_cnt_r;
  logic sclk_rise, le_rise, ref_rise, ce_ok, lock_ok, down;
  logic load_fn, load_dv, load_rf;

  // Pin synchronisers; edge detects use stages 2 and 3 only
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sclk_s_r <= 3'h0;
      le_s_r <= 3'h0;
      ref_s_r <= 3'h0;
      data_s_r <= 2'h0;
      ce_s_r <= 2'h0;
      lock_s_r <= 2'h0;
    end
    else
    begin
      sclk_s_r <= {sclk_s_r[1:0], shift_clk_in};
      le_s_r <= {le_s_r[1:0], load_strobe_in};
      ref_s_r <= {ref_s_r[1:0], ref_div_out_in};
      data_s_r <= {data_s_r[0], shift_data_in};
      ce_s_r <= {ce_s_r[0], chip_enable_in};
      lock_s_r <= {lock_s_r[0], loop_locked_in};
    end
  end

  assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
  assign le_rise = le_s_r[1] & ~le_s_r[2];
  assign ref_rise = ref_s_r[1] & ~ref_s_r[2];
  assign ce_ok = ce_s_r[1];
  assign lock_ok = lock_s_r[1];
  // Shift register accepts data regardless of power state
  assign load_fn = le_rise && shift_r[1:0] == SEL_FUNCTION;
  assign load_rf = le_rise && shift_r[1:0] == SEL_REFERENCE;
  assign load_dv = le_rise && shift_r[1:0] == SEL_DIVIDER;

  // MSB first: new bit enters at the bottom
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      shift_r <= LATCH_RST;
    else if (sclk_rise)
      shift_r <= {shift_r[WORD_W-2:0], data_s_r[1]};
  end

  // Latch transfer on strobe rise; test-latch code ignored
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      fn_r <= LATCH_RST;
      rf_r <= LATCH_RST;
      dv_r <= LATCH_RST;
    end
    else
    begin
      if (load_fn)
        fn_r <= shift_r;
      if (load_rf)
        rf_r <= shift_r;
      if (load_dv)
        dv_r <= shift_r;
    end
  end

  // Pump gain follows the most recent writer
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      gain_r <= 1'b0;
    else if (load_dv)
      gain_r <= shift_r[DV_GAIN];
    else if (load_fn)
      gain_r <= shift_r[FN_GAIN];
  end

  // First function load brings circuits up
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      powered_r <= 1'b0;
    else if (load_fn)
      powered_r <= 1'b1;
  end

  // Divider load asks for a band search; power cycling alone never does.
  // A request made while down waits for power to return.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      band_req_r <= 1'b0;
    else if (load_dv)
      band_req_r <= 1'b1;
    else if (!down)
      band_req_r <= 1'b0;
  end

  // Programmed power-down: immediate or reference-gated
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pd_r <= 1'b0;
      sync_pend_r <= 1'b0;
      edge_cnt_r <= 2'h0;
    end
    else if (load_fn)
    begin
      edge_cnt_r <= 2'h0;
      if (!shift_r[FN_PD_ARM])
      begin
        pd_r <= 1'b0;
        sync_pend_r <= 1'b0;
      end
      else if (!shift_r[FN_PD_SYNC])
      begin
        pd_r <= 1'b1;
        sync_pend_r <= 1'b0;
      end
      else
        sync_pend_r <= 1'b1;
    end
    else if (sync_pend_r && ref_rise)
    begin
      if (edge_cnt_r == SYNC_EDGES - 2'h1)
      begin
        pd_r <= 1'b1;
        sync_pend_r <= 1'b0;
      end
      edge_cnt_r <= edge_cnt_r + 2'h1;
    end
  end

  assign down = !ce_ok || pd_r || !powered_r;

  assign function_control_latch_out = fn_r;
  assign reference_divider_latch_out = rf_r;
  assign divider_word_latch_out = dv_r;
  assign prescaler_select_out = fn_r[FN_PRESCALER_HI:FN_PRESCALER_LO];
  assign pump_gain_select_out = gain_r;
  assign pump_current_out = gain_r ? fn_r[FN_CUR2_HI:FN_CUR2_LO]
                                   : fn_r[FN_CUR1_HI:FN_CUR1_LO];
  assign pump_tristate_out = fn_r[FN_TRISTATE] || down;
  assign counters_hold_out = down;
  assign lock_detect_clear_out = down;
  assign ref_buffer_enable_out = !down;
  assign rf_output_enable_out = !down
    && (!fn_r[FN_MUTE] || lock_ok);
  assign powered_up_out = powered_r;
  assign band_search_out = band_req_r && !down;
  assign powered_down_out = down;

  a_async_pd: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_fn && shift_r[FN_PD_ARM] && !shift_r[FN_PD_SYNC]
    |=> powered_down_out)
    else $error("Immediate power-down missed");
  a_sync_wait: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_fn && shift_r[FN_PD_ARM] && shift_r[FN_PD_SYNC] && !pd_r
    ##1 (!ref_rise && !load_fn) |=> !pd_r)
    else $error("Synchronous power-down too early");
  a_sync_done: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    sync_pend_r && ref_rise && edge_cnt_r == 2'h1 && !load_fn
    |=> pd_r)
    else $error("Synchronous power-down late");
  a_sync_early: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    sync_pend_r && !pd_r && !load_fn
    && !(ref_rise && edge_cnt_r == 2'h1) |=> !pd_r)
    else $error("Synchronous power-down before second edge");
  a_edge_restart: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_fn |=> edge_cnt_r == 2'h0)
    else $error("Reference edge count not restarted");
  a_pd_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    pd_r && !load_fn |=> pd_r)
    else $error("Programmed power-down dropped");
  a_pd_cancel: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_fn && !shift_r[FN_PD_ARM] |=> !pd_r && !sync_pend_r)
    else $error("Programmed power-down not cancelled");
  a_ce_low: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !ce_s_r[1] |-> powered_down_out && !rf_output_enable_out)
    else $error("Chip enable low not honoured");
  a_down_fx: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    powered_down_out |-> pump_tristate_out && counters_hold_out
    && !ref_buffer_enable_out)
    else $error("Power-down effects missing");
  a_down_lock: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    powered_down_out |-> lock_detect_clear_out && !rf_output_enable_out)
    else $error("Lock detect or output stage left on");
  a_shift_in: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    sclk_rise |=> shift_r[0] == $past(data_s_r[1]))
    else $error("Shift bit lost");
  a_fn_load: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_fn |=> fn_r == $past(shift_r) && powered_r)
    else $error("Function latch not loaded");
  a_dv_load: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_dv |=> dv_r == $past(shift_r)
    && gain_r == $past(shift_r[DV_GAIN]))
    else $error("Divider latch not loaded");
  a_rf_load: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_rf |=> rf_r == $past(shift_r))
    else $error("Reference latch not loaded");
  a_fn_keep: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !load_fn |=> $stable(fn_r))
    else $error("Function latch changed without a load");
  a_rf_keep: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !load_rf |=> $stable(rf_r))
    else $error("Reference latch changed without a load");
  a_dv_keep: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !load_dv |=> $stable(dv_r))
    else $error("Divider latch changed without a load");
  a_up_sticky: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    powered_r |=> powered_r)
    else $error("Power-up state lost");
  a_up_cause: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(powered_r) |-> $past(load_fn))
    else $error("Powered up without a function load");
  a_mute_lock: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    fn_r[FN_MUTE] && !lock_s_r[1] |-> !rf_output_enable_out)
    else $error("Output on while unlocked");
  a_rf_on: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !powered_down_out && !fn_r[FN_MUTE] |-> rf_output_enable_out)
    else $error("Output stage off while enabled");
  a_gain_cur: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    gain_r |-> pump_current_out == fn_r[FN_CUR2_HI:FN_CUR2_LO])
    else $error("Wrong pump current setting");
  a_gain_cur1: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !gain_r |-> pump_current_out == fn_r[FN_CUR1_HI:FN_CUR1_LO])
    else $error("Wrong first pump current setting");
  a_fn_gain: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    load_fn |=> gain_r == $past(shift_r[FN_GAIN]))
    else $error("Pump gain not taken from function latch");
  a_gain_keep: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !load_fn && !load_dv |=> $stable(gain_r))
    else $error("Pump gain changed without a write");
  a_tri_bit: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    fn_r[FN_TRISTATE] |-> pump_tristate_out)
    else $error("Pump not three-stated");
  a_tri_off: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !fn_r[FN_TRISTATE] && !powered_down_out |-> !pump_tristate_out)
    else $error("Pump three-stated in normal operation");
  a_band_keep: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    powered_down_out && !load_dv && !band_req_r |=> !band_search_out)
    else $error("Band search without a divider load");
  a_band_down: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    powered_down_out |-> !band_search_out)
    else $error("Band search while powered down");
  a_band_once: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    band_search_out && !load_dv |=> !band_search_out)
    else $error("Band search repeated");

  c_async: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    load_fn && shift_r[FN_PD_ARM] && !shift_r[FN_PD_SYNC]);
  c_sync: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    sync_pend_r ##1 pd_r);
  c_div_load: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    load_dv);
  c_ce_drop: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    powered_r && !pd_r && !ce_s_r[1]);
  c_mute_go: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    fn_r[FN_MUTE] && $rose(rf_output_enable_out));
endmodule : slp_core

/* tb/slp_host_model.sv */
/*
  Host model that writes 24-bit words over the three-wire link.
  Assumes clk_in is the bench clock; pins move at its falling edge.
*/
module slp_host_model #(
  // Shortened settle wait in clk_in cycles
  parameter int SETTLE_CYC = 400
) (
  // Clock
  input wire logic clk_in,
  // Serial link
  output logic shift_clk_out,
  output logic shift_data_out,
  output logic load_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    shift_clk_out = 1'b0;
    shift_data_out = 1'b0;
    load_strobe_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  // Stand-in for the host's settling wait; the core does not time it
  task automatic settle;
    wt(SETTLE_CYC);
  endtask : settle
  // Shift clock stands low between words
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      shift_data_out = w[i];
      wt(4);
      shift_clk_out = 1'b1;
      wt(4);
      shift_clk_out = 1'b0;
    end
    shift_data_out = ~w[0];
    load_strobe_out = 1'b1;
    wt(4);
    load_strobe_out = 1'b0;
    wt(6);
  endtask : send
endmodule : slp_host_model

/* tb/synth_latch_programming_powerdown_test.sv */
/*
  Self-checking bench for the latch bank and power-down control.
  Assumes the host model and the core share clk_in.
*/
module synth_latch_programming_powerdown_test;
  import slp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [23:0] w;
    logic [2:0] cur;
    logic [1:0] pre;
    logic pd;
  } slp_row_t;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce = 1'b1;
  logic refd = 1'b0;
  logic lock = 1'b0;
  logic sck, sda, sle;
  logic [23:0] fn, rf, dv;
  logic [1:0] pre;
  logic [2:0] cur;
  logic gain, tri_o, hold, ldc, rfen, refen, up, band, pd;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int band_cnt = 0;
  always #2.5 clk_in = ~clk_in;
  slp_host_model u_slp_host_model (.clk_in(clk_in), .shift_clk_out(sck),
    .shift_data_out(sda), .load_strobe_out(sle));
  slp_core u_slp_core (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .shift_clk_in(sck), .shift_data_in(sda), .load_strobe_in(sle),
    .chip_enable_in(ce), .ref_div_out_in(refd), .loop_locked_in(lock),
    .function_control_latch_out(fn), .reference_divider_latch_out(rf),
    .divider_word_latch_out(dv), .prescaler_select_out(pre),
    .pump_current_out(cur), .pump_gain_select_out(gain),
    .pump_tristate_out(tri_o), .counters_hold_out(hold),
    .lock_detect_clear_out(ldc), .rf_output_enable_out(rfen),
    .ref_buffer_enable_out(refen), .powered_up_out(up),
    .band_search_out(band), .powered_down_out(pd));
  task automatic chk(input string n, input logic [23:0] e,
    input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task automatic pulse;
    refd = 1'b1;
    wt(4);
    refd = 1'b0;
    wt(4);
  endtask : pulse
  task automatic snd(input logic [23:0] w);
    u_slp_host_model.send(w);
  endtask : snd
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fails++;
      final_report();
    end
  end
  // Band search pulses, counted where they stand
  always @(negedge clk_in)
    if (band === 1'b1)
      band_cnt++;
  initial
  begin
    slp_row_t rows [4];
    rows[0] = '{24'h30a5a5, 3'h0, 2'h0, 1'b1};
    rows[1] = '{24'h0a8000, 3'h2, 2'h0, 1'b0};
    rows[2] = '{24'hca8400, 3'h5, 2'h3, 1'b0};
    rows[3] = '{24'h01234e, 3'h2, 2'h3, 1'b0};
    wt(10);
    rst_b_in = 1'b1;
    wt(2);
    chk("pd_rst", 24'h1, 24'(pd));
    chk("up_rst", 24'h0, 24'(up));
    foreach (rows[i])
    begin
      if (rows[i].w[1:0] == SEL_DIVIDER)
        u_slp_host_model.settle();
      snd(rows[i].w);
      chk("latch", rows[i].w, rows[i].w[1:0] == SEL_FUNCTION ? fn :
        rows[i].w[1:0] == SEL_REFERENCE ? rf : dv);
      chk("cur", 24'(rows[i].cur), 24'(cur));
      chk("pre", 24'(rows[i].pre), 24'(pre));
      chk("pd", 24'(rows[i].pd), 24'(pd));
    end
    chk("gain_dv0", 24'h0, 24'(gain));
    chk("up", 24'h1, 24'(up));
    chk("band1", 24'h1, 24'(band_cnt));
    // Select code 3 leaves every latch alone
    snd(24'hffffff);
    chk("fn3", 24'hca8400, fn);
    chk("dv3", 24'h01234e, dv);
    snd(24'h100000);
    chk("pd_async", 24'h1, 24'(pd));
    chk("pd_fx", 24'h1c, 24'({hold, ldc, tri_o, rfen, refen}));
    snd(24'h000005);
    chk("rf_down", 24'h000005, rf);
    snd(24'h000000);
    chk("pd_off", 24'h0, 24'(pd));
    snd(24'h300000);
    chk("pd_sync0", 24'h0, 24'(pd));
    pulse();
    chk("pd_sync1", 24'h0, 24'(pd));
    pulse();
    chk("pd_sync2", 24'h1, 24'(pd));
    snd(24'h000200);
    chk("tri", 24'h2, 24'({tri_o, pd}));
    snd(24'h000800);
    chk("mute", 24'h0, 24'(rfen));
    lock = 1'b1;
    wt(4);
    chk("unmute", 24'h1, 24'(rfen));
    ce = 1'b0;
    wt(4);
    chk("ce_low", 24'h2, 24'({pd, rfen}));
    ce = 1'b1;
    wt(4);
    chk("ce_high", 24'h0, 24'(pd));
    chk("band_ce", 24'h1, 24'(band_cnt));
    snd(24'h21234e);
    chk("dv_gain", 24'h21234e, dv);
    chk("gain_dv1", 24'h1, 24'(gain));
    chk("band2", 24'h2, 24'(band_cnt));
    // Reset in mid-run
    rst_b_in = 1'b0;
    wt(2);
    chk("fn_mid", 24'h0, fn);
    chk("rst_mid", 24'hc, 24'({pd, tri_o, up, rfen}));
    rst_b_in = 1'b1;
    wt(2);
    chk("rst_rel", 24'h1, 24'(pd));
    chk("band_rst", 24'h2, 24'(band_cnt));
    final_report();
  end
endmodule : synth_latch_programming_powerdown_test
